// ===== src/pws_params.svh
`ifndef PWS_PARAMS_SVH
`define PWS_PARAMS_SVH
// ****************
// Widths
// ****************
`define PWS_DW        16
`define PWS_PCT_W     7
// ****************
// Hysteresis percentages
// ****************
`define PWS_PCT_START 7'h01
`define PWS_PCT_STOP  7'h05
`define PWS_PCT_DIV   7'h64
`endif

// ===== src/pws_pkg.sv
`include "pws_params.svh"
package pws_pkg;
    // ****************
    // Source combinations
    // ****************
    typedef enum logic [2:0] {
        PWS_M_EXT_MAN   = 3'h0,
        PWS_M_EXT_STOP  = 3'h1,
        PWS_M_EXT_COND  = 3'h2,
        PWS_M_COND_ALL  = 3'h3,
        PWS_M_COND_EXT  = 3'h4,
        PWS_M_COND_LAPS = 3'h5
    } pws_mode_t;

    typedef enum logic [2:0] {
        PWS_S_IDLE  = 3'h0,
        PWS_S_RUN   = 3'h1,
        PWS_S_STOPD = 3'h2,
        PWS_S_FIN   = 3'h3,
        PWS_S_VALID = 3'h4
    } pws_state_t;

    // ****************
    // Carriers
    // ****************
    typedef struct packed {
        logic                       axis_y;
        logic                       above;
        logic signed [`PWS_DW-1:0]  ref_v;
    } pws_cond_t;

    typedef struct packed {
        pws_mode_t  mode;
        pws_cond_t  start_c;
        pws_cond_t  stop_c;
        pws_cond_t  fin_c;
    } pws_cfg_t;

    typedef struct packed {
        logic signed [`PWS_DW-1:0]  x_lo;
        logic signed [`PWS_DW-1:0]  x_hi;
        logic signed [`PWS_DW-1:0]  y_lo;
        logic signed [`PWS_DW-1:0]  y_hi;
    } pws_win_t;

    typedef struct packed {
        logic signed [`PWS_DW-1:0]  x;
        logic signed [`PWS_DW-1:0]  y;
    } pws_smp_t;
endpackage

// ===== src/pws_thresh.sv
`timescale 1ns/1ps
`default_nettype none
`include "pws_params.svh"
module pws_thresh #(
    parameter int DW = `PWS_DW
) (
    // Clock and reset
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_rst_b,
    // Condition setup
    input  wire pws_pkg::pws_cond_t     i_cond,
    input  wire pws_pkg::pws_win_t      i_win,
    input  wire logic [`PWS_PCT_W-1:0]  i_pct,
    input  wire logic                   i_lapse,
    input  wire logic                   i_en,
    // Raw samples
    input  wire pws_pkg::pws_smp_t      i_smp,
    input  wire logic                   i_smp_vld,
    // Result
    output logic                        o_hit
);
    localparam int EW = DW + 10;

    logic signed [EW-1:0]  span;
    logic signed [EW-1:0]  hyst;
    logic signed [EW-1:0]  val;
    logic signed [EW-1:0]  refv;
    logic                  arm_r;
    logic                  arm_nxt;
    logic                  lvl_ok;

    // ****************
    // Hysteresis
    // ****************
    always_comb begin
        span = i_cond.axis_y ? (EW'(i_win.y_hi) - EW'(i_win.y_lo))
                             : (EW'(i_win.x_hi) - EW'(i_win.x_lo));
        hyst = (span * $signed({1'b0, i_pct})) / $signed(EW'(`PWS_PCT_DIV));
        val  = i_cond.axis_y ? EW'(i_smp.y) : EW'(i_smp.x);
        refv = EW'(i_cond.ref_v);
        lvl_ok = i_cond.above ? (val < refv - hyst) : (val > refv + hyst);
    end

    // ****************
    // Arming
    // ****************
    always_comb begin
        arm_nxt = arm_r;
        if (!i_en) begin
            arm_nxt = 1'b0;
        end else if (i_smp_vld && lvl_ok) begin
            arm_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            arm_r <= 1'b0;
        end else begin
            arm_r <= arm_nxt;
        end
    end

    always_comb begin
        o_hit = 1'b0;
        if (i_en && i_smp_vld) begin
            if (i_lapse) begin
                o_hit = i_cond.above ? (val < refv - hyst) : (val > refv + hyst);
            end else begin
                o_hit = arm_r && (i_cond.above ? (val > refv) : (val < refv));
            end
        end
    end

    // ****************
    // Checks
    // ****************
    a_hit_needs_arm: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (o_hit && !i_lapse) |-> arm_r)
        else $error("threshold hit before arming");
    a_arm_drops_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        !i_en |=> !arm_r)
        else $error("arm flag survived disable");
endmodule
`default_nettype wire

// ===== src/pws_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "pws_params.svh"
// Contract
// - No data store and no ready until the process has ended.
// - Interface start and end act exactly like manual start and end.
// - With mixed control, first of manual or external edge starts or ends.
// - External start and end act on edges only; held levels do nothing.
// - After a manual start, threshold stop and end are ignored.
// - External end edge, manual or interface end halts at once.
// - In condition modes, manual or interface end aborts immediately.
// - A threshold arms only after the value crossed the hysteresis level once.
// - Hysteresis is 1 percent for start, 5 percent for stop and end.
// - Hysteresis uses the range window span of the monitored axis.
// - Falls-below conditions arm above the reference.
// - Exceeds conditions arm below the reference.
// - Lapse mode ends when value recrosses start reference by start hysteresis.
// - Conditions are checked on every raw sample.
// - Outputs run started, finished, then result valid, per sources.
module pws_sequencer #(
    parameter int DW = `PWS_DW
) (
    // Clock and reset
    input  wire logic               i_ref_clk,
    input  wire logic               i_rst_b,
    // Configuration
    input  wire pws_pkg::pws_cfg_t  i_cfg,
    input  wire pws_pkg::pws_win_t  i_win,
    // Raw sample stream
    input  wire pws_pkg::pws_smp_t  i_smp,
    input  wire logic               i_smp_vld,
    // External digital inputs
    input  wire logic               i_ext_start,
    input  wire logic               i_ext_end,
    // Manual and interface commands
    input  wire logic               i_man_start,
    input  wire logic               i_man_end,
    input  wire logic               i_if_start,
    input  wire logic               i_if_end,
    // Status
    output logic                    o_started,
    output logic                    o_acq,
    output logic                    o_finished,
    output logic                    o_store_en,
    output logic                    o_result_valid,
    output logic                    o_ready
);
    pws_pkg::pws_state_t  state_r;
    pws_pkg::pws_state_t  state_nxt;
    logic                 man_r;
    logic                 man_nxt;
    logic [2:0]           xs_r;
    logic [2:0]           xe_r;
    logic                 xs_edge;
    logic                 xe_edge;
    logic                 m_ext_start;
    logic                 m_cond_start;
    logic                 m_ext_end;
    logic                 m_cond_end;
    logic                 m_lapse;
    logic                 start_go;
    logic                 user_end;
    logic                 abort;
    logic [3:0]           cen;
    logic [3:0]           hit;
    pws_pkg::pws_cond_t   cond_a [4];

    // ****************
    // Input synchronisers
    // ****************
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            xs_r <= 3'h0;
            xe_r <= 3'h0;
        end else begin
            xs_r <= {xs_r[1:0], i_ext_start};
            xe_r <= {xe_r[1:0], i_ext_end};
        end
    end

    assign xs_edge = xs_r[1] & ~xs_r[2];
    assign xe_edge = xe_r[1] & ~xe_r[2];

    // ****************
    // Mode decode
    // ****************
    always_comb begin
        m_ext_start  = 1'b0;
        m_cond_start = 1'b0;
        m_ext_end    = 1'b0;
        m_cond_end   = 1'b0;
        m_lapse      = 1'b0;
        case (i_cfg.mode)
            pws_pkg::PWS_M_EXT_MAN: begin
                m_ext_start = 1'b1;
                m_ext_end   = 1'b1;
            end
            pws_pkg::PWS_M_EXT_STOP: begin
                m_ext_start = 1'b1;
                m_ext_end   = 1'b1;
            end
            pws_pkg::PWS_M_EXT_COND: begin
                m_ext_start = 1'b1;
                m_cond_end  = 1'b1;
            end
            pws_pkg::PWS_M_COND_ALL: begin
                m_cond_start = 1'b1;
                m_cond_end   = 1'b1;
            end
            pws_pkg::PWS_M_COND_EXT: begin
                m_cond_start = 1'b1;
                m_ext_end    = 1'b1;
            end
            pws_pkg::PWS_M_COND_LAPS: begin
                m_cond_start = 1'b1;
                m_lapse      = 1'b1;
            end
            default: begin
                m_ext_start = 1'b0;
            end
        endcase
    end

    // ****************
    // Threshold conditions
    // ****************
    always_comb begin
        cond_a[0] = i_cfg.start_c;
        cond_a[1] = i_cfg.stop_c;
        cond_a[2] = i_cfg.fin_c;
        cond_a[3] = i_cfg.start_c;
        cen[0] = (state_r == pws_pkg::PWS_S_IDLE) && m_cond_start;
        cen[1] = (state_r == pws_pkg::PWS_S_RUN) && !man_r &&
                 (i_cfg.mode != pws_pkg::PWS_M_EXT_MAN);
        cen[2] = (state_r == pws_pkg::PWS_S_STOPD) && !man_r && m_cond_end;
        cen[3] = (state_r == pws_pkg::PWS_S_STOPD) && !man_r && m_lapse;
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_cond
            pws_thresh #(
                .DW         (DW)
            ) u_thr (
                .i_ref_clk  (i_ref_clk),
                .i_rst_b    (i_rst_b),
                .i_cond     (cond_a[gi]),
                .i_win      (i_win),
                .i_pct      ((gi == 0 || gi == 3) ? `PWS_PCT_START : `PWS_PCT_STOP),
                .i_lapse    (gi == 3),
                .i_en       (cen[gi]),
                .i_smp      (i_smp),
                .i_smp_vld  (i_smp_vld),
                .o_hit      (hit[gi])
            );
        end
    endgenerate

    // ****************
    // Sequencer
    // ****************
    always_comb begin
        start_go  = i_man_start | i_if_start | (m_ext_start & xs_edge) |
                    (m_cond_start & hit[0]);
        user_end  = i_man_end | i_if_end;
        abort     = user_end | ((m_ext_end | man_r) & xe_edge);
        state_nxt = state_r;
        man_nxt   = man_r;
        case (state_r)
            pws_pkg::PWS_S_IDLE: begin
                if (start_go) begin
                    state_nxt = pws_pkg::PWS_S_RUN;
                    man_nxt   = i_man_start | i_if_start;
                end
            end
            pws_pkg::PWS_S_RUN: begin
                if (abort) begin
                    state_nxt = pws_pkg::PWS_S_FIN;
                end else if (hit[1]) begin
                    state_nxt = pws_pkg::PWS_S_STOPD;
                end
            end
            pws_pkg::PWS_S_STOPD: begin
                if (abort || hit[2] || hit[3]) begin
                    state_nxt = pws_pkg::PWS_S_FIN;
                end
            end
            pws_pkg::PWS_S_FIN: begin
                state_nxt = pws_pkg::PWS_S_VALID;
            end
            pws_pkg::PWS_S_VALID: begin
                state_nxt = pws_pkg::PWS_S_IDLE;
                man_nxt   = 1'b0;
            end
            default: begin
                state_nxt = pws_pkg::PWS_S_IDLE;
                man_nxt   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r        <= pws_pkg::PWS_S_IDLE;
            man_r          <= 1'b0;
            o_started      <= 1'b0;
            o_acq          <= 1'b0;
            o_finished     <= 1'b0;
            o_store_en     <= 1'b0;
            o_result_valid <= 1'b0;
            o_ready        <= 1'b0;
        end else begin
            state_r        <= state_nxt;
            man_r          <= man_nxt;
            o_started      <= (state_nxt == pws_pkg::PWS_S_RUN) ||
                              (state_nxt == pws_pkg::PWS_S_STOPD);
            o_acq          <= (state_nxt == pws_pkg::PWS_S_RUN);
            o_finished     <= (state_nxt == pws_pkg::PWS_S_FIN);
            o_store_en     <= (state_nxt == pws_pkg::PWS_S_FIN);
            o_result_valid <= (state_nxt == pws_pkg::PWS_S_VALID);
            o_ready        <= (state_nxt == pws_pkg::PWS_S_IDLE);
        end
    end

    // ****************
    // Checks
    // ****************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);

    a_no_ready_run: assert property (o_started |-> !o_ready && !o_store_en)
        else $error("ready or store during process");
    a_if_start_go: assert property (
        (state_r == pws_pkg::PWS_S_IDLE && i_if_start) |=> o_started && man_r)
        else $error("interface start not taken");
    a_man_first: assert property (
        (state_r == pws_pkg::PWS_S_IDLE && i_man_start) |=> o_started && o_acq)
        else $error("manual start not taken");
    a_level_no_trig: assert property (
        (state_r == pws_pkg::PWS_S_IDLE && !m_cond_start && !xs_edge &&
         !i_man_start && !i_if_start) |=> !o_started)
        else $error("start without an edge");
    a_man_no_cond: assert property (
        (state_r == pws_pkg::PWS_S_RUN && man_r && !user_end && !xe_edge)
        |=> state_r == pws_pkg::PWS_S_RUN)
        else $error("condition acted after manual start");
    a_ext_end_halt: assert property (
        (o_started && m_ext_end && xe_edge) |=> o_finished ##1 o_result_valid)
        else $error("external end did not halt");
    a_user_abort: assert property (
        (o_started && user_end) |=> o_finished && !o_started)
        else $error("user end did not abort");
    a_seq_order: assert property (
        o_finished |=> o_result_valid && !o_finished ##1 o_ready && !o_result_valid)
        else $error("status sequence broken");

    c_stop_then_end: cover property (o_acq ##1 (o_started && !o_acq) ##[1:50] o_finished);
    c_ext_run: cover property (xs_edge ##1 o_started ##[1:50] o_result_valid);
    c_lapse_end: cover property (hit[3] ##1 o_finished);
endmodule
`default_nettype wire

// ===== tb/pws_bench_ctl.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Bench controller pins
// ****************
module pws_bench_ctl (
    // Pins towards the sequencer
    output logic o_ext_start,
    output logic o_ext_end
);
    initial begin
        o_ext_start = 1'b0;
        o_ext_end   = 1'b0;
    end

    // Pins change at a chosen offset, unrelated to the sequencer clock
    task automatic drive(input logic s, input logic e, input int dly);
        #(dly);
        o_ext_start = s;
        o_ext_end   = e;
    endtask
endmodule
`default_nettype wire

// ===== tb/pws_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pws_sequencer_tb_top;
    localparam int XS = 32'h0000_03E8;
    localparam int YS = 32'h0000_07D0;
    logic              i_ref_clk;
    logic              i_rst_b;
    pws_pkg::pws_cfg_t i_cfg;
    pws_pkg::pws_win_t i_win;
    pws_pkg::pws_smp_t i_smp;
    logic              i_smp_vld;
    logic              i_man_start;
    logic              i_man_end;
    logic              i_if_start;
    logic              i_if_end;
    wire logic         ext_s;
    wire logic         ext_e;
    logic              o_started;
    logic              o_acq;
    logic              o_finished;
    logic              o_store_en;
    logic              o_result_valid;
    logic              o_ready;
    int                err_count;
    int                n_compared;
    int                seed;
    int                i;
    wire logic [5:0]   stat = {o_started, o_acq, o_finished, o_store_en, o_result_valid, o_ready};

    pws_bench_ctl i_pws_bench_ctl (.o_ext_start(ext_s), .o_ext_end(ext_e));

    pws_sequencer i_pws_sequencer (
        .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_cfg(i_cfg), .i_win(i_win),
        .i_smp(i_smp), .i_smp_vld(i_smp_vld), .i_ext_start(ext_s), .i_ext_end(ext_e),
        .i_man_start(i_man_start), .i_man_end(i_man_end), .i_if_start(i_if_start),
        .i_if_end(i_if_end), .o_started(o_started), .o_acq(o_acq), .o_finished(o_finished),
        .o_store_en(o_store_en), .o_result_valid(o_result_valid), .o_ready(o_ready)
    );

    // ****************
    // Helpers
    // ****************
    function automatic int hyst(input int span, input int pct);
        return span * pct / 100;
    endfunction

    function automatic pws_pkg::pws_cond_t cnd(input logic y, input logic a, input int r);
        return '{axis_y: y, above: a, ref_v: 16'(r)};
    endfunction

    task automatic chk(input logic [5:0] seen, input logic [5:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results;
        if (err_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic tick;
        @(negedge i_ref_clk);
        if (i_smp_vld) i_smp_vld = 1'b0;
        if (i_man_start) i_man_start = 1'b0;
        if (i_man_end) i_man_end = 1'b0;
        if (i_if_start) i_if_start = 1'b0;
        if (i_if_end) i_if_end = 1'b0;
    endtask

    task automatic smpv(input int x, input int y);
        i_smp     = '{x: 16'(x), y: 16'(y)};
        i_smp_vld = 1'b1;
    endtask

    task automatic smp(input int x, input int y);
        smpv(x, y);
        tick;
        tick;
    endtask

    // End walk: finish with store, then result valid, then ready
    task automatic wait_fin(input int n);
        int k;
        tick;
        for (k = 1; k < n && o_finished !== 1'b1; k++) begin
            tick;
        end
        chk(stat, 6'h0C);
        tick;
        chk(stat, 6'h02);
        tick;
        chk(stat, 6'h01);
    endtask

    task automatic wait_st(input int n);
        int k;
        tick;
        for (k = 1; k < n && o_started !== 1'b1; k++) begin
            tick;
        end
        chk(stat, 6'h30);
    endtask

    task automatic cstart;
        smp(600 - hyst(XS, 1) - 1, 1200);
        smp(601, 1200);
        chk(stat, 6'h30);
    endtask

    initial begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end

    initial begin
        repeat (20000) @(posedge i_ref_clk);
        err_count++;
        results;
    end

    // ****************
    // Main sequence
    // ****************
    initial begin
        seed = 45;
        err_count = 0;
        n_compared = 0;
        i_rst_b = 1'b0;
        i_cfg = '0;
        i_win = '{x_lo: 16'sh0000, x_hi: 16'sh03E8, y_lo: 16'sh0000, y_hi: 16'sh07D0};
        i_smp = '0;
        i_smp_vld = 1'b0;
        i_man_start = 1'b0;
        i_man_end = 1'b0;
        i_if_start = 1'b0;
        i_if_end = 1'b0;
        repeat (10) @(negedge i_ref_clk);
        i_rst_b = 1'b1;
        tick;
        chk(stat, 6'h01);
        i_cfg.mode = pws_pkg::PWS_M_COND_ALL;
        i_cfg.start_c = cnd(1'b1, 1'b1, 1000);
        i_cfg.stop_c = cnd(1'b0, 1'b0, 500);
        i_cfg.fin_c = cnd(1'b1, 1'b0, 300);
        for (i = 0; i < 2; i++) begin
            if (i == 0) i_man_start = 1'b1; else i_if_start = 1'b1;
            tick;
            chk(stat, 6'h30);
            smp(551, 1500);
            smp(499, 401);
            smp(499, 299);
            chk(stat, 6'h30);
            if (i == 0) i_man_end = 1'b1; else i_if_end = 1'b1;
            wait_fin(1);
        end
        i_pws_bench_ctl.drive(1'b1, 1'b0, 7);
        repeat (5) tick;
        chk(stat, 6'h01);
        i_pws_bench_ctl.drive(1'b0, 1'b0, 3);
        smp(0, 1500);
        smp(0, 1000 - hyst(YS, 1));
        smp(0, 1500);
        chk(stat, 6'h01);
        smp(0, 1000 - hyst(YS, 1) - 1);
        smp(0, 1001);
        chk(stat, 6'h30);
        smp(500 + hyst(XS, 5), 1001);
        smp(400, 1001);
        chk(stat, 6'h30);
        smp(500 + hyst(XS, 5) + 1, 1001);
        smp(499, 1001);
        chk(stat, 6'h20);
        smp(499, 300 + hyst(YS, 5) / 2 + 1);
        smp(499, 299);
        chk(stat, 6'h20);
        smp(499, 300 + hyst(YS, 5) + 1);
        smpv(499, 299);
        wait_fin(3);
        i_cfg.mode = pws_pkg::PWS_M_EXT_MAN;
        i_pws_bench_ctl.drive(1'b1, 1'b0, 7);
        wait_st(5);
        i_man_start = 1'b1;
        tick;
        chk(stat, 6'h30);
        i_pws_bench_ctl.drive(1'b1, 1'b1, 13);
        wait_fin(6);
        repeat (6) tick;
        chk(stat, 6'h01);
        i_man_start = 1'b1;
        tick;
        chk(stat, 6'h30);
        i_pws_bench_ctl.drive(1'b1, 1'b0, 5);
        repeat (4) tick;
        i_pws_bench_ctl.drive(1'b0, 1'b1, 5);
        wait_fin(6);
        i_pws_bench_ctl.drive(1'b0, 1'b0, 5);
        i_cfg.mode = pws_pkg::PWS_M_EXT_STOP;
        i_pws_bench_ctl.drive(1'b1, 1'b0, 9);
        wait_st(5);
        smp(551, 0);
        i_pws_bench_ctl.drive(1'b0, 1'b1, 9);
        wait_fin(6);
        i_pws_bench_ctl.drive(1'b0, 1'b0, 9);
        i_cfg.mode = pws_pkg::PWS_M_EXT_COND;
        i_pws_bench_ctl.drive(1'b1, 1'b0, 9);
        wait_st(5);
        smp(551, 0);
        smp(499, 0);
        chk(stat, 6'h20);
        i_if_end = 1'b1;
        wait_fin(1);
        i_pws_bench_ctl.drive(1'b0, 1'b0, 9);
        i_cfg.start_c = cnd(1'b0, 1'b1, 600);
        i_cfg.stop_c = cnd(1'b1, 1'b0, 1000);
        i_cfg.mode = pws_pkg::PWS_M_COND_EXT;
        cstart;
        i_pws_bench_ctl.drive(1'b0, 1'b1, 9);
        wait_fin(6);
        i_pws_bench_ctl.drive(1'b0, 1'b0, 9);
        i_cfg.mode = pws_pkg::PWS_M_COND_LAPS;
        cstart;
        smp(601, 1200);
        smp(601, 999);
        smp(600 - hyst(XS, 1), 999);
        chk(stat, 6'h20);
        smpv(600 - hyst(XS, 1) - 1, 999);
        wait_fin(3);
        i_cfg.mode = pws_pkg::pws_mode_t'(3'h6);
        for (i = 0; i < 300; i++) begin
            smpv($unsigned($random(seed)) % 1001, $unsigned($random(seed)) % 2001);
            tick;
            i_pws_bench_ctl.drive(1'($random(seed)), 1'($random(seed)), 3);
            tick;
        end
        chk(stat, 6'h01);
        results;
    end
endmodule
`default_nettype wire
